/* File: ars_defs.svh */
// ----------------------------------------------------------------------
// constants of the automatic restart supervisor
// ----------------------------------------------------------------------
// definitions only; included by the package and all modules but ars_partner
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH

// clock and timebase
`define ARS_CLK_NS      20
`define ARS_TICK_NS     1000000
`define ARS_PROVE_S     1
`define ARS_PROVE_MS    (`ARS_PROVE_S * 1000)

// register byte offsets
`define ARS_OFS_MODE    5'h00
`define ARS_OFS_LIMIT   5'h04
`define ARS_OFS_WAIT    5'h08
`define ARS_OFS_MON     5'h0c
`define ARS_OFS_STAT    5'h10
`define ARS_OFS_ISTAT   5'h14
`define ARS_OFS_IMASK   5'h18

// reset values (times in 1 ms ticks)
`define ARS_RST_MODE    5'h00
`define ARS_RST_LIMIT   8'h03
`define ARS_RST_WAIT    16'h03e8
`define ARS_RST_MON     16'hea60
`define ARS_RST_CRT     16'h0000

// restart mode codes
`define ARS_M_OFF       5'h00
`define ARS_M_ACK       5'h01
`define ARS_M_PF        5'h04
`define ARS_M_FLT       5'h06
`define ARS_M_PF_MAN    5'h0e
`define ARS_M_FLT_MAN   5'h10
`define ARS_M_ALL       5'h1a

// interrupt bit positions
`define ARS_IRQ_EXH     0
`define ARS_IRQ_ACK     1
`define ARS_IRQ_ON      2
`define ARS_IRQ_OK      3
`define ARS_IRQ_W       4

`endif

/* File: ars_pkg.sv */
// ----------------------------------------------------------------------
// types of the automatic restart supervisor
// ----------------------------------------------------------------------
// needs ars_defs.svh on the include path
`include "ars_defs.svh"

package ars_pkg;

    // supervisor states
    typedef enum logic [2:0] {
        ARS_IDLE  = 3'b000,
        ARS_ACKW  = 3'b001,
        ARS_WAIT  = 3'b010,
        ARS_START = 3'b011,
        ARS_PROVE = 3'b100,
        ARS_RUN   = 3'b101,
        ARS_EXH   = 3'b110
    } ars_state_t;

    // software settings
    typedef struct packed {
        logic [4:0]  mode;
        logic [7:0]  limit;
        logic [15:0] wait_ms;
        logic [15:0] mon_ms;
        logic [15:0] crt_ms;
    } ars_cfg_t;

endpackage : ars_pkg

/* File: ars_tick.sv */
// ----------------------------------------------------------------------
// millisecond tick prescaler
// ----------------------------------------------------------------------
// one pulse every DIV clocks; clock is mclk, reset async low
`timescale 1ns/10ps
`include "ars_defs.svh"

module ars_tick
    import ars_pkg::*;
#(
    parameter int DIV = `ARS_TICK_NS / `ARS_CLK_NS
)(
    input  wire logic mclk,
    input  wire logic arst_n,
    output logic      tick
);

    // refuse a divider the counter cannot serve
    generate
        if (DIV < 2 || DIV > 65536)
        begin : g_bad
            $error("ars_tick: DIV out of range");
        end
    endgenerate

    logic [15:0] div_r;
    logic        last_w;

    assign last_w = (div_r == 16'(DIV - 1));
    assign tick   = last_w;

    // free running divider
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            div_r <= 16'h0000;
        else
            div_r <= last_w ? 16'h0000 : div_r + 16'h0001;
    end

endmodule : ars_tick

/* File: ars_top.sv */
// ----------------------------------------------------------------------
// automatic restart supervisor of a motor inverter
// ----------------------------------------------------------------------
// avalon-mm slave with waitrequest, one clock mclk at 50 MHz,
// event inputs are one-cycle pulses synchronous to mclk
//
// Functional notes
// - mode resets to 0, 0 is inactive
// - six restart modes supported besides 0
// - attempt limit resets to 3
// - limit used only in modes 4,6,14,16,26
// - each acknowledgement decrements attempt counter
// - limit 0 or 1 gives one attempt
// - limit n gives n attempts, then fault
// - reload counter after counter-reset time
// - reload after ramp stop and acknowledge
// - reload on changed limit or mode
// - wait time resets to 1.0 s
// - wait used only in modes 4,6,26
// - switch-on delayed by wait after fault
// - auto acknowledge per mode and run command
// - auto switch-on only with run command
// - success: no fault 1 s after magnetized
// - monitoring time expiry raises exhausted fault
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "ars_defs.svh"

module ars_top
    import ars_pkg::*;
#(
    parameter int TICK_DIV = `ARS_TICK_NS / `ARS_CLK_NS
)(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        fault_evt,
    input  wire logic        power_fail_evt,
    input  wire logic        run_command,
    input  wire logic        ramp_stop_command,
    input  wire logic        manual_ack,
    input  wire logic        magnetizing_done_flag,
    output logic             auto_ack,
    output logic             auto_on_req,
    output logic             restart_exhausted_fault,
    output logic             irq
);

    // ------------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------------
    ars_cfg_t                 cfg_r;
    ars_state_t               state_r, state_nxt;
    logic [7:0]               cnt_r, cnt_nxt;
    logic [15:0]              tmr_r, mon_cnt_r;
    logic                     mon_run_r, mon_run_nxt;
    logic [`ARS_IRQ_W-1:0]    ist_r, imask_r, ev_w;
    logic                     ack_r, auto_ack_r, auto_on_r, exh_r;
    logic [31:0]              rdata_r, rd_mux, wmask;
    logic                     tick, req, wr_go;
    logic                     m_ack, m_pf, m_flt, m_pfm, m_fltm, m_all;
    logic                     mode_on, lim_used, wait_used, manual;
    logic                     trig, ack_ok, ack_go, auto_ack_go;
    logic                     wait_done, prove_done, crt_done, mon_exp;
    logic [7:0]               lim_eff, lim_src, lim_rld;
    logic                     wr_mode, wr_lim, reload_chg;
    logic [4:0]               mode_wd;
    logic [7:0]               lim_wd;

    // ------------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------------
    ars_tick #(
        .DIV    (TICK_DIV)
    ) u_tick (
        .mclk   (mclk),
        .arst_n (arst_n),
        .tick   (tick)
    );

    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, then the answer
    // ------------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // read selection, unmapped reads as zero
    always_comb
    begin
        case (avs_address)
            `ARS_OFS_MODE:  rd_mux = {27'h0, cfg_r.mode};
            `ARS_OFS_LIMIT: rd_mux = {24'h0, cfg_r.limit};
            `ARS_OFS_WAIT:  rd_mux = {16'h0, cfg_r.wait_ms};
            `ARS_OFS_MON:   rd_mux = {cfg_r.crt_ms, cfg_r.mon_ms};
            `ARS_OFS_STAT:  rd_mux = {13'h0, mon_run_r, auto_on_r, exh_r,
                                      cnt_r, 5'h0, state_r};
            `ARS_OFS_ISTAT: rd_mux = {28'h0, ist_r};
            `ARS_OFS_IMASK: rd_mux = {28'h0, imask_r};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // handshake and read data
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r   <= req & ~ack_r;
            rdata_r <= (avs_read & ~ack_r) ? rd_mux : rdata_r;
        end
    end
    assign avs_readdata = rdata_r;

    // ------------------------------------------------------------------
    // settings
    // ------------------------------------------------------------------
    assign mode_wd = avs_byteenable[0] ? avs_writedata[4:0] : cfg_r.mode;
    assign lim_wd  = avs_byteenable[0] ? avs_writedata[7:0] : cfg_r.limit;
    assign wr_mode = wr_go & (avs_address == `ARS_OFS_MODE);
    assign wr_lim  = wr_go & (avs_address == `ARS_OFS_LIMIT);
    assign reload_chg = (wr_mode & (mode_wd != cfg_r.mode)) |
                        (wr_lim & (lim_wd != cfg_r.limit));

    // setting registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_r.mode    <= `ARS_RST_MODE;
            cfg_r.limit   <= `ARS_RST_LIMIT;
            cfg_r.wait_ms <= `ARS_RST_WAIT;
            cfg_r.mon_ms  <= `ARS_RST_MON;
            cfg_r.crt_ms  <= `ARS_RST_CRT;
        end
        else if (wr_go)
        begin
            if (wr_mode)
                cfg_r.mode <= mode_wd;
            if (wr_lim)
                cfg_r.limit <= lim_wd;
            if (avs_address == `ARS_OFS_WAIT)
                cfg_r.wait_ms <= (cfg_r.wait_ms & ~wmask[15:0])
                               | (avs_writedata[15:0] & wmask[15:0]);
            if (avs_address == `ARS_OFS_MON)
            begin
                cfg_r.mon_ms <= (cfg_r.mon_ms & ~wmask[15:0])
                              | (avs_writedata[15:0] & wmask[15:0]);
                cfg_r.crt_ms <= (cfg_r.crt_ms & ~wmask[31:16])
                              | (avs_writedata[31:16] & wmask[31:16]);
            end
        end
    end

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    assign m_ack     = (cfg_r.mode == `ARS_M_ACK);
    assign m_pf      = (cfg_r.mode == `ARS_M_PF);
    assign m_flt     = (cfg_r.mode == `ARS_M_FLT);
    assign m_pfm     = (cfg_r.mode == `ARS_M_PF_MAN);
    assign m_fltm    = (cfg_r.mode == `ARS_M_FLT_MAN);
    assign m_all     = (cfg_r.mode == `ARS_M_ALL);
    assign lim_used  = m_pf | m_flt | m_pfm | m_fltm | m_all;
    assign mode_on   = m_ack | lim_used;
    assign wait_used = m_pf | m_flt | m_all;
    assign manual    = m_pfm | m_fltm;
    assign lim_eff   = (cfg_r.limit == 8'h00) ? 8'h01 : cfg_r.limit;
    // a limit write reloads with the value being written, not the old one
    assign lim_src   = wr_lim ? lim_wd : cfg_r.limit;
    assign lim_rld   = (lim_src == 8'h00) ? 8'h01 : lim_src;

    // power-failure modes restart only on supply loss
    assign trig = lim_used & (power_fail_evt | (fault_evt & ~m_pf & ~m_pfm));

    // automatic acknowledge condition
    assign ack_ok = m_ack | m_all | ((m_pf | m_flt) & run_command);

    // timer comparisons in ms ticks
    assign wait_done  = ~wait_used | (tmr_r >= cfg_r.wait_ms);
    assign prove_done = (tmr_r >= 16'(`ARS_PROVE_MS));
    assign crt_done   = (tmr_r >= cfg_r.crt_ms);
    assign mon_exp    = mon_run_r & (cfg_r.mon_ms != 16'h0000)
                      & (mon_cnt_r >= cfg_r.mon_ms);

    // ------------------------------------------------------------------
    // restart sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        mon_run_nxt = mon_run_r;
        ack_go      = 1'b0;
        auto_ack_go = m_ack & (fault_evt | power_fail_evt);
        case (state_r)
            ARS_IDLE, ARS_START, ARS_PROVE, ARS_RUN:
            begin
                if (trig)
                begin
                    mon_run_nxt = 1'b1;
                    if (manual | ~ack_ok)
                        state_nxt = ARS_ACKW;
                    else
                        ack_go = 1'b1;
                end
                else if (state_r == ARS_START && magnetizing_done_flag)
                    state_nxt = ARS_PROVE;
                else if (state_r == ARS_PROVE && prove_done)
                begin
                    state_nxt   = ARS_RUN;
                    mon_run_nxt = 1'b0;
                end
                else if (state_r == ARS_RUN && crt_done)
                begin
                    state_nxt = ARS_IDLE;
                    cnt_nxt   = lim_eff;
                end
            end
            ARS_ACKW:
                ack_go = manual ? manual_ack : ack_ok;
            ARS_WAIT:
                if (wait_done && run_command)
                    state_nxt = ARS_START;
            ARS_EXH:
                if (manual_ack && ramp_stop_command)
                begin
                    state_nxt = ARS_IDLE;
                    cnt_nxt   = lim_eff;
                end
            default:
                state_nxt = ARS_IDLE;
        endcase
        if (ack_go)
        begin
            auto_ack_go = ~manual;
            if (cnt_r == 8'h00)
                state_nxt = ARS_EXH;
            else
            begin
                cnt_nxt   = cnt_r - 8'h01;
                state_nxt = ARS_WAIT;
            end
        end
        if (mon_exp && state_r != ARS_EXH)
            state_nxt = ARS_EXH;
        if (state_nxt == ARS_EXH || state_nxt == ARS_IDLE)
            mon_run_nxt = 1'b0;
        if (reload_chg)
            cnt_nxt = lim_rld;
        if (!mode_on)
        begin
            state_nxt   = ARS_IDLE;
            mon_run_nxt = 1'b0;
            auto_ack_go = 1'b0;
        end
    end

    // state, counters and outputs
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r    <= ARS_IDLE;
            cnt_r      <= `ARS_RST_LIMIT;
            tmr_r      <= 16'h0000;
            mon_cnt_r  <= 16'h0000;
            mon_run_r  <= 1'b0;
            auto_ack_r <= 1'b0;
            auto_on_r  <= 1'b0;
            exh_r      <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            mon_run_r  <= mon_run_nxt;
            auto_ack_r <= auto_ack_go;
            auto_on_r  <= (state_nxt == ARS_START) | (state_nxt == ARS_PROVE);
            exh_r      <= (state_nxt == ARS_EXH);
            // time in state, saturating
            if (state_nxt != state_r)
                tmr_r <= 16'h0000;
            else if (tick && tmr_r != 16'hffff)
                tmr_r <= tmr_r + 16'h0001;
            // monitoring time since the fault
            if (!mon_run_nxt || !mon_run_r)
                mon_cnt_r <= 16'h0000;
            else if (tick && mon_cnt_r != 16'hffff)
                mon_cnt_r <= mon_cnt_r + 16'h0001;
        end
    end

    assign auto_ack                = auto_ack_r;
    assign auto_on_req             = auto_on_r;
    assign restart_exhausted_fault = exh_r;

    // ------------------------------------------------------------------
    // interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------------
    assign ev_w[`ARS_IRQ_EXH] = (state_nxt == ARS_EXH) & ~exh_r;
    assign ev_w[`ARS_IRQ_ACK] = auto_ack_go;
    assign ev_w[`ARS_IRQ_ON]  = (state_nxt == ARS_START) & (state_r != ARS_START);
    assign ev_w[`ARS_IRQ_OK]  = (state_nxt == ARS_RUN) & (state_r == ARS_PROVE);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ist_r   <= '0;
            imask_r <= '0;
        end
        else
        begin
            if (wr_go && avs_address == `ARS_OFS_ISTAT && avs_byteenable[0])
                ist_r <= (ist_r & ~avs_writedata[`ARS_IRQ_W-1:0]) | ev_w;
            else
                ist_r <= ist_r | ev_w;
            if (wr_go && avs_address == `ARS_OFS_IMASK && avs_byteenable[0])
                imask_r <= avs_writedata[`ARS_IRQ_W-1:0];
        end
    end
    assign irq = |(ist_r & imask_r);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_ack_live;
        ack_go && cnt_r != 8'h00 && !reload_chg && mode_on && !mon_exp;
    endsequence
    sequence s_ack_last;
        ack_go && cnt_r == 8'h00 && mode_on;
    endsequence

    property p_mode_off;
        !mode_on |=> !auto_on_req && !auto_ack && state_r == ARS_IDLE;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("outputs active in mode 0");

    property p_dec;
        s_ack_live |=> cnt_r == $past(cnt_r) - 8'h01 && state_r == ARS_WAIT;
    endproperty
    a_dec: assert property (p_dec)
        else $error("attempt counter not decremented");

    property p_last;
        s_ack_last |=> restart_exhausted_fault;
    endproperty
    a_last: assert property (p_last)
        else $error("exhausted fault missing after last attempt");

    property p_reload;
        reload_chg |=> cnt_r == lim_eff;
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter not reloaded on setting change");

    property p_man_ack;
        manual |=> !auto_ack;
    endproperty
    a_man_ack: assert property (p_man_ack)
        else $error("auto acknowledge in manual mode");

    property p_on_run;
        $rose(auto_on_req) |-> $past(run_command) && $past(state_r) == ARS_WAIT;
    endproperty
    a_on_run: assert property (p_on_run)
        else $error("switch-on without run command");

    property p_wait;
        state_r == ARS_WAIT && state_nxt == ARS_START && wait_used
            |-> tmr_r >= cfg_r.wait_ms;
    endproperty
    a_wait: assert property (p_wait)
        else $error("switch-on before wait time");

    property p_prove;
        state_r == ARS_PROVE && state_nxt == ARS_RUN |-> tmr_r >= 16'(`ARS_PROVE_MS);
    endproperty
    a_prove: assert property (p_prove)
        else $error("success declared early");

    property p_mon;
        mon_exp && mode_on |=> restart_exhausted_fault ##1 restart_exhausted_fault;
    endproperty
    a_mon: assert property (p_mon)
        else $error("monitoring expiry did not raise fault");

endmodule : ars_top

/* File: ars_partner.sv */
// far side model: inverter fault logic and magnetization status
// assumes mclk and arst_n of the supervisor; tb requests events as one-cycle pulses
`timescale 1ns/10ps

module ars_partner
    import ars_pkg::*;
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic auto_on_req,
    input  wire logic slow,
    input  wire logic fail_att,
    input  wire logic [2:0] ev,
    output logic      fault_evt,
    output logic      power_fail_evt,
    output logic      manual_ack,
    output logic      magnetizing_done_flag
);
    // ------------------------------------------------------------------
    // magnetization and tripping
    // ------------------------------------------------------------------
    logic [7:0] cnt_r;

    // magnetize after a short or long delay; a failing attempt trips soon after
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r                 <= 8'h00;
            magnetizing_done_flag <= 1'b0;
            {fault_evt, power_fail_evt, manual_ack} <= 3'b000;
        end
        else
        begin
            cnt_r <= !auto_on_req ? 8'h00 : (cnt_r == 8'hff ? cnt_r : cnt_r + 8'h01);
            magnetizing_done_flag <= auto_on_req && cnt_r >= (slow ? 8'h28 : 8'h04);
            fault_evt      <= ev[0] || (fail_att && cnt_r == (slow ? 8'h30 : 8'h0c));
            power_fail_evt <= ev[1];
            manual_ack     <= ev[2];
        end
    end
endmodule : ars_partner

/* File: tb_top.sv */
// self-checking bench of the automatic restart supervisor
// assumes ars_pkg, ars_top and ars_partner are compiled first
`timescale 1ns/10ps
`include "ars_defs.svh"

module tb_top
    import ars_pkg::*;
;
    // ------------------------------------------------------------------
    // signals, instances and helpers
    // ------------------------------------------------------------------
    localparam int TD = 4;
    logic        mclk, arst_n, avs_read, avs_write, run_command, ramp_stop_command;
    logic        slow, fail_att, avs_waitrequest, fault_evt, power_fail_evt, manual_ack;
    logic        magnetizing_done_flag, auto_ack, auto_on_req, restart_exhausted_fault;
    logic        irq, on_q;
    logic [2:0]  ev;
    logic [3:0]  avs_byteenable;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, dq;
    int          error_cnt, checked, n_ack, n_on, n, a, w;
    wire logic [2:0] obs = {restart_exhausted_fault, auto_on_req, auto_ack};

    ars_top #(.TICK_DIV(TD)) u_ars_top (.mclk(mclk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .fault_evt(fault_evt), .power_fail_evt(power_fail_evt), .run_command(run_command),
        .ramp_stop_command(ramp_stop_command), .manual_ack(manual_ack),
        .magnetizing_done_flag(magnetizing_done_flag), .auto_ack(auto_ack),
        .auto_on_req(auto_on_req), .restart_exhausted_fault(restart_exhausted_fault),
        .irq(irq));
    ars_partner u_ars_partner (.mclk(mclk), .arst_n(arst_n), .auto_on_req(auto_on_req),
        .slow(slow), .fail_att(fail_att), .ev(ev), .fault_evt(fault_evt),
        .power_fail_evt(power_fail_evt), .manual_ack(manual_ack),
        .magnetizing_done_flag(magnetizing_done_flag));

    task automatic results;
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic hang(input string nm);
        chk(nm, 32'h1, 32'h0);
        results();
    endtask : hang

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr_en, input logic [4:0] ad, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int  k;
        logic wq;
        avs_address    <= ad;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr_en;
        avs_read       <= !wr_en;
        k = 0;
        do
        begin
            @(negedge mclk);
            wq = avs_waitrequest;
            q = avs_readdata;
            @(posedge mclk);
            k++;
        end
        while (wq !== 1'b0 && k < 20);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (k >= 20)
            hang("bus answer");
        @(posedge mclk);
    endtask : bus

    task automatic wr(input logic [4:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad, d, 4'hf, q);
    endtask : wr

    task automatic rdc(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
        logic [31:0] q;
        bus(1'b0, ad, 32'h0, 4'hf, q);
        chk(nm, e, q & m);
    endtask : rdc

    // bounded wait for an output to reach a level, counted in cycles
    task automatic wt(input int i, input logic v, input int lim, output int k);
        k = 0;
        do
        begin
            @(negedge mclk);
            k++;
        end
        while (obs[i] !== v && k < lim);
        if (k >= lim)
            hang("output wait");
        @(posedge mclk);
    endtask : wt

    task automatic pulse(input logic [2:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 3'b000;
    endtask : pulse

    // failing attempts until exhausted, then ramp stop and acknowledge
    task automatic tries(input logic [7:0] lim, input int att);
        int a0;
        int k;
        wr(`ARS_OFS_LIMIT, {24'h0, lim});
        wr(`ARS_OFS_MODE, 32'h6);
        fail_att <= 1'b1;
        a0 = n_on;
        pulse(3'b001);
        wt(2, 1'b1, 400, k);
        chk("attempts", att, n_on - a0);
        fail_att <= 1'b0;
        ramp_stop_command <= 1'b1;
        pulse(3'b100);
        repeat (2) @(posedge mclk);
        ramp_stop_command <= 1'b0;
        rdc(`ARS_OFS_STAT, 32'hff00, {16'h0, (lim > 1 ? lim : 8'h1), 8'h0}, "left");
    endtask : tries

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // counts acknowledge pulses and switch-on rises
    always @(posedge mclk)
    begin
        n_ack += (auto_ack === 1'b1);
        n_on += (auto_on_req === 1'b1 && on_q !== 1'b1);
        on_q <= auto_on_req;
    end

    initial
    begin
        {arst_n, avs_read, avs_write, run_command, ramp_stop_command, slow, fail_att, ev,
         avs_byteenable, avs_address, avs_writedata, on_q} = '0;
        seed = 32'd79001;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdc(`ARS_OFS_MODE, 32'h1f, 32'h0, "mode");
        rdc(`ARS_OFS_LIMIT, 32'hff, 32'h3, "limit");
        rdc(`ARS_OFS_WAIT, 32'hffff, 32'h3e8, "wait");
        rdc(`ARS_OFS_STAT, 32'hff07, 32'h0300, "stat");
        rdc(5'h1c, 32'hffffffff, 32'h0, "unmapped");
        run_command <= 1'b1;
        pulse(3'b001);
        repeat (20) @(posedge mclk);
        chk("ack off", 32'h0, n_ack);
        wr(`ARS_OFS_MODE, 32'h1);
        pulse(3'b001);
        repeat (4) @(posedge mclk);
        chk("ack m1", 32'h1, n_ack);
        chk("on m1", 32'h0, n_on);
        rdc(`ARS_OFS_ISTAT, 32'h2, 32'h2, "istat");
        chk("irq masked", 32'h0, irq);
        wr(`ARS_OFS_IMASK, 32'h2);
        chk("irq", 32'h1, irq);
        wr(`ARS_OFS_ISTAT, 32'h2);
        chk("irq clr", 32'h0, irq);
        // no run command: no acknowledge, monitor expiry exhausts
        run_command <= 1'b0;
        wr(`ARS_OFS_MON, 32'h8);
        wr(`ARS_OFS_MODE, 32'h6);
        pulse(3'b001);
        repeat (8) @(posedge mclk);
        chk("ack norun", 32'h1, n_ack);
        wt(2, 1'b1, 80, n);
        chk("mon time", 32'h1, 32'(n > 16 && n < 34));
        ramp_stop_command <= 1'b1;
        pulse(3'b100);
        repeat (3) @(posedge mclk);
        chk("exh clr", 32'h0, restart_exhausted_fault);
        ramp_stop_command <= 1'b0;
        wr(`ARS_OFS_LIMIT, 32'h5);
        bus(1'b1, `ARS_OFS_LIMIT, 32'h9, 4'h0, dq);
        rdc(`ARS_OFS_STAT, 32'hff00, 32'h0500, "reload");
        // manual acknowledge mode, slow magnetization, success
        run_command <= 1'b1;
        slow <= 1'b1;
        wr(`ARS_OFS_MON, 32'h0005_0000);
        wr(`ARS_OFS_WAIT, 32'h2);
        wr(`ARS_OFS_MODE, 32'he);
        a = n_ack;
        pulse(3'b001);
        pulse(3'b010);
        repeat (10) @(posedge mclk);
        chk("ack m14", a, n_ack);
        chk("on m14", 32'h0, n_on);
        pulse(3'b100);
        wt(1, 1'b1, 20, n);
        chk("no wait", 32'h1, 32'(n < 5));
        wt(1, 1'b0, 4300, n);
        chk("prove", 32'h1, 32'(n > 3950));
        slow <= 1'b0;
        repeat (40) @(posedge mclk);
        tries(8'h0, 1);
        tries(8'h3, 3);
        // random wait times in the acknowledge-all and supply-loss modes
        for (int i = 0; i < 2; i++)
        begin
            wr(`ARS_OFS_MODE, i ? 32'h4 : 32'h1a);
            w = 1 + int'(xs() % 6);
            wr(`ARS_OFS_WAIT, 32'(w));
            pulse(i ? 3'b010 : 3'b001);
            wt(1, 1'b1, 200, n);
            chk("delay", 32'h1, 32'(n >= (w - 1) * TD && n <= (w + 1) * TD + 6));
            wt(1, 1'b0, 4300, n);
            rdc(`ARS_OFS_STAT, 32'hff07, 32'h0205, "run");
            repeat (40) @(posedge mclk);
            rdc(`ARS_OFS_STAT, 32'hff07, 32'h0300, "crt");
        end
        results();
    end
endmodule : tb_top
